// >>> logic/ep_status_map.svh
// Register offsets, bit positions, reset values and the rule summary.
// Summary of operation
// R01 - While stall request is set the next handshake on the endpoint is a STALL.
// R02 - Firmware loads IN data only while packet ready is clear, then sets packet ready.
// R03 - Packet ready set with no data written sends a zero length packet.
// R04 - Packet ready clears after sending on isochronous, after host ACK otherwise.
// R05 - Non-isochronous endpoints set stall sent after a requested STALL and interrupt; the code sets it only for a STALL answering an IN token.
// R06 - Non-isochronous endpoints clear stall sent when a SETUP packet arrives.
// R07 - Isochronous endpoints use the same flag as a data CRC error flag and interrupt.
// R08 - Isochronous endpoints clear the CRC error flag on later good data.
// R09 - Storing an OUT packet in bank 0 sets bank 0 received and interrupts.
// R10 - While bank 0 received is set, OUT to bank 0 is NAKed except on isochronous.
// R11 - On control endpoints a SETUP may overwrite the buffer while bank 0 is full.
// R12 - Firmware clears bank 0 received after reading the OUT data.
// R13 - Transmit complete sets after sending (iso) or host ACK (others) and interrupts.
// R14 - A valid SETUP sets setup received, is stored, and interrupts.
// R15 - In ping-pong mode bank 1 received sets on storing and NAKs bank 1 until cleared; the code does not NAK bank 1 on isochronous endpoints.
`ifndef EP_STATUS_MAP_SVH
`define EP_STATUS_MAP_SVH
`define OFS_STATUS 4'h0
`define OFS_MASK 4'h4
`define OFS_CONFIG 4'h8
`define BIT_IN_CMP 0
`define BIT_OUT_B0 1
`define BIT_SETUP 2
`define BIT_STALL_CRC 3
`define BIT_IN_RDY 4
`define BIT_STALL_RQ 5
`define BIT_OUT_B1 6
`define RST_STATUS 8'h00
`define RST_MASK 8'h00
`define FLAG_MASK 8'h4F
`define WR_MASK 8'h30
`endif

// >>> logic/ep_status_pkg.sv
// Types shared by the endpoint status block.
package ep_status_pkg;
  typedef enum logic [1:0] {
    ep_control, ep_bulk, ep_interrupt, ep_isochronous
  } ep_kind_type;
  typedef enum logic [1:0] {
    hs_none, hs_ack, hs_nak, hs_stall
  } handshake_type;
  typedef enum logic [1:0] {
    bus_idle, bus_ack
  } bus_state_type;
endpackage

// >>> logic/sticky_flag.sv
// One hardware-set flag where a set in the clear cycle wins.
module sticky_flag (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Events.
  input wire logic set,
  input wire logic clr,
  // State.
  output logic flag
);
  typedef struct packed {
    logic f;
  } state_type;
  state_type s_q;
  state_type s_d;
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.f = 1'b0;
    end
    if (set) begin
      s_d.f = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign flag = s_q.f;
  a_set_wins: assert property (@(posedge mclk) disable iff (rst)
    set |=> flag)
    else $error("flag lost a set");
endmodule // sticky_flag

// >>> logic/ep_status.sv
// Endpoint status and handshake control flags with an Avalon-MM slave.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`include "ep_status_map.svh"
module ep_status (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Endpoint kind and ping-pong mode.
  input wire logic [1:0] ep_kind,
  input wire logic ping_pong,
  // Events from the USB transaction engine, one-cycle pulses.
  input wire logic setup_rx,
  input wire logic out_rx_ok,
  input wire logic out_rx_bank,
  input wire logic out_rx_crc_err,
  input wire logic in_token,
  input wire logic in_sent,
  input wire logic in_acked,
  // Decisions to the transaction engine.
  output logic [1:0] handshake,
  output logic out_accept_bank0,
  output logic out_accept_bank1,
  output logic in_send_data,
  output logic in_zero_length,
  // Firmware data path and interrupt.
  input wire logic in_data_written,
  output logic endpoint_irq
);
  typedef struct packed {
    logic stall_request;
    logic in_packet_ready;
    logic in_has_data;
    logic [7:0] mask;
    ep_status_pkg::bus_state_type bus;
    logic [31:0] rdata;
  } state_type;
  state_type s_q;
  state_type s_d;
  logic iso;
  logic b0_full;
  logic b1_full;
  logic sent_stall;
  logic [7:0] status;
  logic take;
  logic [7:0] clr_w1;
  logic st_in_cmp;
  logic st_out_b0;
  logic st_setup;
  logic st_stall_crc;
  logic st_out_b1;
  logic status_wr;
  logic mask_wr;

  assign iso = (ep_kind == 2'h3);
  assign status_wr = take && write && address == `OFS_STATUS;
  assign mask_wr = take && write && address == `OFS_MASK;
  assign take = (read | write) && s_q.bus == ep_status_pkg::bus_ack;
  assign waitrequest = (read | write) && s_q.bus != ep_status_pkg::bus_ack;
  assign clr_w1 = (take && write && address == `OFS_STATUS) ?
                  writedata[7:0] & `FLAG_MASK : 8'h00;
  assign sent_stall = in_token && s_q.stall_request && !iso;

  // Handshake chosen for the current token.
  always_comb begin
    handshake = ep_status_pkg::hs_ack;
    if (s_q.stall_request) begin
      handshake = ep_status_pkg::hs_stall; // see R01
    end else if (out_rx_ok && !iso &&
                 ((ping_pong && out_rx_bank) ? b1_full : b0_full)) begin
      handshake = ep_status_pkg::hs_nak; // see R10 R15
    end
  end
  // A SETUP always lands in the buffer, even over a full bank 0.
  assign out_accept_bank0 = iso || setup_rx || !b0_full; // see R10 R11
  assign out_accept_bank1 = ping_pong && (iso || !b1_full); // see R15
  assign in_send_data = s_q.in_packet_ready && !s_q.stall_request;
  assign in_zero_length = in_send_data && !s_q.in_has_data; // see R03

  sticky_flag u_cmp (.mclk(mclk), .rst(rst), // see R13
    .set((iso && in_sent) || (!iso && in_acked)),
    .clr(clr_w1[`BIT_IN_CMP]), .flag(st_in_cmp));
  sticky_flag u_b0 (.mclk(mclk), .rst(rst), // see R09 R12
    .set(out_rx_ok && !out_rx_crc_err && !out_rx_bank &&
         (iso || !b0_full)),
    .clr(clr_w1[`BIT_OUT_B0]), .flag(st_out_b0));
  sticky_flag u_setup (.mclk(mclk), .rst(rst), // see R14
    .set(setup_rx), .clr(clr_w1[`BIT_SETUP]), .flag(st_setup));
  // Hardware clears on a non-iso SETUP or good iso data, unless an event sets it.
  sticky_flag u_stall (.mclk(mclk), .rst(rst), // see R05 R07
    .set(sent_stall || (iso && out_rx_ok && out_rx_crc_err)),
    .clr(clr_w1[`BIT_STALL_CRC] || (!iso && setup_rx) || // see R06
         (iso && out_rx_ok && !out_rx_crc_err)), // see R08
    .flag(st_stall_crc));
  sticky_flag u_b1 (.mclk(mclk), .rst(rst), // see R15
    .set(ping_pong && out_rx_ok && !out_rx_crc_err && out_rx_bank &&
         (iso || !b1_full)),
    .clr(clr_w1[`BIT_OUT_B1]), .flag(st_out_b1));

  assign b0_full = st_out_b0;
  assign b1_full = st_out_b1;
  always_comb begin
    status = 8'h00;
    status[`BIT_IN_CMP] = st_in_cmp;
    status[`BIT_OUT_B0] = st_out_b0;
    status[`BIT_SETUP] = st_setup;
    status[`BIT_STALL_CRC] = st_stall_crc;
    status[`BIT_IN_RDY] = s_q.in_packet_ready;
    status[`BIT_STALL_RQ] = s_q.stall_request;
    status[`BIT_OUT_B1] = st_out_b1;
  end
  assign endpoint_irq = |(status & `FLAG_MASK & s_q.mask);

  always_comb begin
    s_d = s_q;
    s_d.bus = ((read | write) && s_q.bus == ep_status_pkg::bus_idle) ?
              ep_status_pkg::bus_ack : ep_status_pkg::bus_idle;
    // Firmware loads data only while ready is clear; track any data.
    if (in_data_written && !s_q.in_packet_ready) begin // see R02
      s_d.in_has_data = 1'b1;
    end
    if ((iso && in_sent) || (!iso && in_acked)) begin // see R04
      s_d.in_packet_ready = 1'b0;
      s_d.in_has_data = 1'b0;
    end
    if (take && write) begin
      unique case (address)
        `OFS_STATUS: begin
          s_d.stall_request = writedata[`BIT_STALL_RQ];
          if (writedata[`BIT_IN_RDY]) begin
            s_d.in_packet_ready = 1'b1;
          end
        end
        `OFS_MASK: s_d.mask = writedata[7:0] & `FLAG_MASK;
        // The config word only echoes the pins, so writes are dropped.
        `OFS_CONFIG: ;
        default: ;
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (read && s_q.bus == ep_status_pkg::bus_idle) begin
      unique case (address)
        `OFS_STATUS: s_d.rdata = {24'h00_0000, status};
        `OFS_MASK: s_d.rdata = {24'h00_0000, s_q.mask};
        `OFS_CONFIG: s_d.rdata = {29'h0000_0000, ping_pong, ep_kind};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end else if (s_q.bus == ep_status_pkg::bus_ack) begin
      s_d.rdata = s_q.rdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign readdata = s_q.rdata;

  // Bus contract: a fresh request is held off one cycle, then accepted.
  sequence bus_req_start;
    (read || write) && s_q.bus == ep_status_pkg::bus_idle;
  endsequence

  sequence bus_req_held;
    bus_req_start ##1 (read || write);
  endsequence

  a_bus_wait: assert property (@(posedge mclk)
    disable iff (rst) bus_req_start |-> waitrequest)
    else $error("fresh request not held off");

  a_bus_accept: assert property (@(posedge mclk)
    disable iff (rst) bus_req_held |-> !waitrequest)
    else $error("held request not accepted");

  a_bus_idle: assert property (@(posedge mclk)
    disable iff (rst) !(read || write) |-> !waitrequest)
    else $error("wait asserted with no request");

  a_stall_hs: assert property (@(posedge mclk) // see R01
    disable iff (rst)
    s_q.stall_request |-> handshake == ep_status_pkg::hs_stall)
    else $error("stall request not answered with STALL");

  a_stall_wr: assert property (@(posedge mclk) // see R01
    disable iff (rst)
    status_wr |=> s_q.stall_request == $past(writedata[`BIT_STALL_RQ]))
    else $error("stall request not written");

  a_stall_flag: assert property (@(posedge mclk) // see R05
    disable iff (rst) sent_stall |=> st_stall_crc)
    else $error("stall sent flag not set");

  a_setup_clr: assert property (@(posedge mclk) // see R06
    disable iff (rst)
    (!iso && setup_rx && !sent_stall) |=> !st_stall_crc)
    else $error("stall sent not cleared by SETUP");

  a_crc_set: assert property (@(posedge mclk) // see R07
    disable iff (rst)
    (iso && out_rx_ok && out_rx_crc_err) |=> st_stall_crc)
    else $error("crc flag not set");

  a_crc_clr: assert property (@(posedge mclk) // see R08
    disable iff (rst)
    (iso && out_rx_ok && !out_rx_crc_err) |=> !st_stall_crc)
    else $error("crc flag not cleared");

  // A SETUP may overwrite a full bank, so it is left out here.
  a_nak_full: assert property (@(posedge mclk) // see R10
    disable iff (rst)
    (!iso && b0_full && !setup_rx) |-> !out_accept_bank0)
    else $error("full bank 0 accepted OUT");

  a_nak_b0: assert property (@(posedge mclk) // see R10
    disable iff (rst)
    (out_rx_ok && !iso && !s_q.stall_request && !out_rx_bank && b0_full)
    |-> handshake == ep_status_pkg::hs_nak)
    else $error("OUT to full bank 0 not NAKed");

  a_setup_ovr: assert property (@(posedge mclk) // see R11
    disable iff (rst) setup_rx |-> out_accept_bank0)
    else $error("SETUP refused by full bank 0");

  a_b0_set: assert property (@(posedge mclk) // see R09
    disable iff (rst)
    (out_rx_ok && !out_rx_crc_err && !out_rx_bank && (iso || !b0_full))
    |=> st_out_b0)
    else $error("bank 0 received not set");

  a_b0_irq: assert property (@(posedge mclk) // see R09
    disable iff (rst)
    (out_rx_ok && !out_rx_crc_err && !out_rx_bank && (iso || !b0_full) &&
     s_q.mask[`BIT_OUT_B0] && !mask_wr) |=> endpoint_irq)
    else $error("bank 0 interrupt missing");

  a_b0_clr: assert property (@(posedge mclk) // see R12
    disable iff (rst) (clr_w1[`BIT_OUT_B0] && !out_rx_ok) |=> !st_out_b0)
    else $error("bank 0 received not cleared");

  a_rdy_clear: assert property (@(posedge mclk) // see R04
    disable iff (rst)
    (!iso && in_acked && !take) |=> !s_q.in_packet_ready)
    else $error("packet ready kept after ACK");

  a_iso_rdy: assert property (@(posedge mclk) // see R04
    disable iff (rst)
    (iso && in_sent && !take) |=> !s_q.in_packet_ready)
    else $error("packet ready kept after iso send");

  a_rdy_hold: assert property (@(posedge mclk) // see R04
    disable iff (rst)
    (s_q.in_packet_ready && !((iso && in_sent) || (!iso && in_acked)))
    |=> s_q.in_packet_ready)
    else $error("packet ready cleared early");

  // Ready set by firmware with nothing loaded must go out empty.
  a_zlp_send: assert property (@(posedge mclk) // see R03
    disable iff (rst)
    (status_wr && writedata[`BIT_IN_RDY] && !s_q.in_has_data &&
     !in_data_written && !s_q.stall_request) |=> in_zero_length)
    else $error("zero length packet not offered");

  a_cmp_set: assert property (@(posedge mclk) // see R13
    disable iff (rst)
    ((iso && in_sent) || (!iso && in_acked)) |=> st_in_cmp)
    else $error("transmit complete not set");

  a_cmp_irq: assert property (@(posedge mclk) // see R13
    disable iff (rst)
    (((iso && in_sent) || (!iso && in_acked)) &&
     s_q.mask[`BIT_IN_CMP] && !mask_wr) |=> endpoint_irq)
    else $error("transmit complete interrupt missing");

  a_irq_level: assert property (@(posedge mclk) // see R14
    disable iff (rst)
    (setup_rx && s_q.mask[`BIT_SETUP] && !mask_wr) |=> endpoint_irq)
    else $error("setup interrupt missing");

  a_setup_set: assert property (@(posedge mclk) // see R14
    disable iff (rst) setup_rx |=> st_setup)
    else $error("setup received not set");

  a_b1_set: assert property (@(posedge mclk) // see R15
    disable iff (rst)
    (ping_pong && out_rx_ok && !out_rx_crc_err && out_rx_bank &&
     (iso || !b1_full)) |=> st_out_b1)
    else $error("bank 1 received not set");

  a_nak_b1: assert property (@(posedge mclk) // see R15
    disable iff (rst)
    (out_rx_ok && !iso && !s_q.stall_request && ping_pong && out_rx_bank &&
     b1_full) |-> handshake == ep_status_pkg::hs_nak)
    else $error("OUT to full bank 1 not NAKed");

  a_b1_clr: assert property (@(posedge mclk) // see R15
    disable iff (rst) (clr_w1[`BIT_OUT_B1] && !out_rx_ok) |=> !st_out_b1)
    else $error("bank 1 received not cleared");
endmodule // ep_status

// >>> verif/usb_host_model.sv
// Model of the USB transaction engine that feeds endpoint events.
module usb_host_model (
  // Clock.
  input wire logic mclk,
  // Events to the endpoint.
  output logic setup_rx,
  output logic out_rx_ok,
  output logic out_rx_bank,
  output logic out_rx_crc_err,
  output logic in_token,
  output logic in_sent,
  output logic in_acked,
  // Handshake decision.
  input wire logic [1:0] handshake
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hs_seen;
  initial begin
    {setup_rx, out_rx_ok, in_token, in_sent, in_acked} = 5'h00;
    out_rx_bank = 1'b0;
    out_rx_crc_err = 1'b0;
  end
  // Qualifiers flip after the pulse, so a stale bank or CRC value is never
  // mistaken for a live one.
  task automatic ev(input logic [4:0] m, input logic b, input logic e);
    {setup_rx, out_rx_ok, in_token, in_sent, in_acked} <= m;
    out_rx_bank <= b;
    out_rx_crc_err <= e;
    @(posedge mclk);
    hs_seen = handshake;
    {setup_rx, out_rx_ok, in_token, in_sent, in_acked} <= 5'h00;
    out_rx_bank <= ~b;
    out_rx_crc_err <= ~e;
    @(posedge mclk);
  endtask
endmodule // usb_host_model

// >>> verif/tb_usb_endpoint_status_flags.sv
// Self-checking bench for the endpoint status flags.
`include "ep_status_map.svh"
module tb_usb_endpoint_status_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, read, write, waitrequest, ping_pong, in_data_written;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [1:0] ep_kind, handshake;
  logic setup_rx, out_rx_ok, out_rx_bank, out_rx_crc_err;
  logic in_token, in_sent, in_acked, endpoint_irq, in_zero_length;
  logic out_accept_bank0, out_accept_bank1, in_send_data;
  logic [3:0] snap;
  int fail_count = 0;
  int compares = 0;
  ep_status i_ep_status (.mclk, .rst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .ep_kind, .ping_pong, .setup_rx, .out_rx_ok,
    .out_rx_bank, .out_rx_crc_err, .in_token, .in_sent, .in_acked,
    .handshake, .out_accept_bank0, .out_accept_bank1, .in_send_data,
    .in_zero_length, .in_data_written, .endpoint_irq);
  usb_host_model i_usb_host_model (.mclk, .setup_rx, .out_rx_ok,
    .out_rx_bank, .out_rx_crc_err, .in_token, .in_sent, .in_acked,
    .handshake);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic results;
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  // One Avalon access; outputs are snapshotted where they are settled.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= {24'h000000, d};
    do begin
      @(posedge mclk);
      q = readdata;
      snap = {out_accept_bank0, in_send_data, in_zero_length, endpoint_irq};
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic st(input logic [7:0] e, input logic [3:0] o);
    bus(1'b0, `OFS_STATUS, 8'h00);
    chk("status", q, {24'h000000, e});
    chk("outputs", {28'h0000000, snap}, {28'h0000000, o});
  endtask
  initial begin
    #200000;
    fail_count++;
    results;
  end
  initial begin
    rst = 1'b1;
    {read, write, ping_pong, in_data_written} = 4'h0;
    address = 4'h0;
    writedata = 32'h00000000;
    ep_kind = 2'h1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    st(8'h00, 4'h8);
    bus(1'b0, 4'hC, 8'h00);
    chk("unmapped", q, 32'h00000000);
    bus(1'b0, `OFS_MASK, 8'h00);
    chk("mask", q, 32'h00000000);
    bus(1'b1, `OFS_MASK, 8'h4F);
    i_usb_host_model.ev(5'h08, 1'b0, 1'b0);
    st(8'h02, 4'h1);
    i_usb_host_model.ev(5'h08, 1'b0, 1'b0);
    chk("nak bank0", {30'h0, i_usb_host_model.hs_seen}, 32'h2);
    bus(1'b1, `OFS_STATUS, 8'h02);
    st(8'h00, 4'h8);
    bus(1'b1, `OFS_STATUS, 8'h20);
    i_usb_host_model.ev(5'h04, 1'b0, 1'b0);
    chk("handshake", {30'h0, i_usb_host_model.hs_seen}, 32'h3);
    st(8'h28, 4'h9);
    i_usb_host_model.ev(5'h10, 1'b0, 1'b0);
    st(8'h24, 4'h9);
    bus(1'b1, `OFS_STATUS, 8'h04);
    bus(1'b1, `OFS_STATUS, 8'h10);
    st(8'h10, 4'hE);
    i_usb_host_model.ev(5'h02, 1'b0, 1'b0);
    st(8'h10, 4'hE);
    i_usb_host_model.ev(5'h01, 1'b0, 1'b0);
    st(8'h01, 4'h9);
    bus(1'b1, `OFS_MASK, 8'h00);
    st(8'h01, 4'h8);
    bus(1'b1, `OFS_STATUS, 8'h01);
    in_data_written <= 1'b1;
    @(posedge mclk);
    in_data_written <= 1'b0;
    bus(1'b1, `OFS_STATUS, 8'h10);
    st(8'h10, 4'hC);
    ep_kind <= 2'h3;
    i_usb_host_model.ev(5'h02, 1'b0, 1'b0);
    st(8'h01, 4'h8);
    bus(1'b1, `OFS_MASK, 8'h4F);
    bus(1'b1, `OFS_STATUS, 8'h01);
    i_usb_host_model.ev(5'h08, 1'b0, 1'b1);
    bus(1'b0, `OFS_STATUS, 8'h00);
    chk("crc flag", q & 32'h08, 32'h08);
    bus(1'b1, `OFS_STATUS, 8'h02);
    i_usb_host_model.ev(5'h08, 1'b0, 1'b0);
    st(8'h02, 4'h9);
    bus(1'b1, `OFS_STATUS, 8'h02);
    ep_kind <= 2'h0;
    ping_pong <= 1'b1;
    i_usb_host_model.ev(5'h08, 1'b0, 1'b0);
    i_usb_host_model.ev(5'h10, 1'b0, 1'b0);
    st(8'h06, 4'h1);
    i_usb_host_model.ev(5'h08, 1'b1, 1'b0);
    st(8'h46, 4'h1);
    i_usb_host_model.ev(5'h08, 1'b1, 1'b0);
    chk("nak bank1", {30'h0, i_usb_host_model.hs_seen}, 32'h2);
    @(negedge mclk);
    chk("bank1 accept", {31'h0, out_accept_bank1}, 32'h0);
    @(posedge mclk);
    results;
  end
endmodule // tb_usb_endpoint_status_flags
